// ===== shared/bus_seq_pkg.sv
// Shared constants, types and decode functions of the bus cycle sequencer
package bus_seq_pkg;

  // Oscillator rate and the divide-by-two system clock
  localparam int unsigned OSC_HZ     = 25_000_000;
  localparam int unsigned SYS_DIVIDE = 2;
  localparam int unsigned SYS_HZ     = OSC_HZ / SYS_DIVIDE;

  // Register map
  localparam int          REG_AW       = 8;
  localparam logic [7:0]  REG_MODE_OFS = 8'h00;

  // Field positions in bus_mode_control
  localparam int          FS_EN_BIT    = 7;
  localparam int          ONE_SHOT_BIT = 6;
  localparam int          IO_TIM_BIT   = 5;
  localparam logic        FS_EN_RST    = 1'b1;
  localparam logic        IO_TIM_RST   = 1'b1;
  localparam logic [7:0]  RD_ZERO      = 8'h00;

  // Address widths
  localparam int          ADDR_W       = 20;
  localparam int          IO_ADDR_W    = 16;
  localparam logic [19:0] IO_ADDR_MASK = 20'h0_ffff;

  typedef enum logic [3:0] {
    CYC_FETCH      = 4'h0,
    CYC_RETURN_FROM_INTERRUPT_FETCH = 4'h1,
    CYC_NMI_ACK    = 4'h2,
    CYC_MASKABLE_INTERRUPT_ZERO_ACK   = 4'h3,
    CYC_MEM_RD     = 4'h4,
    CYC_MEM_WR     = 4'h5,
    CYC_IO_RD      = 4'h6,
    CYC_IO_WR      = 4'h7,
    CYC_INTERNAL   = 4'h8
  } cyc_kind_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_T1   = 5'b0_0010,
    ST_T2   = 5'b0_0100,
    ST_TW   = 5'b0_1000,
    ST_T3   = 5'b1_0000
  } bus_state_e;

  typedef struct packed {
    cyc_kind_e   kind;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } cyc_req_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  dataOut;
    logic        dataOeN;
    logic        memReqN;
    logic        ioReqN;
    logic        rdN;
    logic        wrN;
    logic        fetchN;
  } bus_pins_s;

  localparam bus_pins_s PINS_IDLE = '{addr: '0, dataOut: '0, dataOeN: 1'b1,
    memReqN: 1'b1, ioReqN: 1'b1, rdN: 1'b1, wrN: 1'b1, fetchN: 1'b1};

  function automatic logic isIo(input cyc_kind_e k);
    return (k == CYC_IO_RD) || (k == CYC_IO_WR) || (k == CYC_MASKABLE_INTERRUPT_ZERO_ACK);
  endfunction : isIo

  function automatic logic isWrite(input cyc_kind_e k);
    return (k == CYC_MEM_WR) || (k == CYC_IO_WR);
  endfunction : isWrite

  function automatic logic isFetchLike(input cyc_kind_e k);
    return (k == CYC_FETCH) || (k == CYC_RETURN_FROM_INTERRUPT_FETCH) || (k == CYC_NMI_ACK);
  endfunction : isFetchLike

  function automatic logic isOpFetch(input cyc_kind_e k);
    return (k == CYC_FETCH) || (k == CYC_RETURN_FROM_INTERRUPT_FETCH);
  endfunction : isOpFetch

endpackage : bus_seq_pkg

// ===== src/sys_clock_divider.sv
// Divide-by-two system clock phase generator
`timescale 1ns/1ps
`default_nettype none
module sys_clock_divider
  import bus_seq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  output var  logic firstHalf,
  output var  logic sysClkOut
);

  typedef struct packed {
    logic secondHalf;
  } div_s;

  div_s q;
  div_s d;

  always_comb begin
    d = q;
    d.secondHalf = ~q.secondHalf;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign firstHalf = ~q.secondHalf;
  // High in the first half of each state, like the system clock
  assign sysClkOut = ~q.secondHalf;

endmodule : sys_clock_divider
`default_nettype wire

// ===== src/bus_mode_regs.sv
// Bus mode control register with software port
`timescale 1ns/1ps
`default_nettype none
module bus_mode_regs
  import bus_seq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [REG_AW-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [7:0]        regRdata,
  input  wire logic              oneShotTaken,
  output var  logic              fetchEnable,
  output var  logic              ioTiming,
  output var  logic              oneShotArmed
);

  typedef struct packed {
    logic       fsEn;
    logic       ioTim;
    logic       armed;
    logic [7:0] rdata;
  } regs_s;

  regs_s q;
  regs_s d;
  logic  hit;

  always_comb begin
    d = q;
    hit = (regAddr == REG_MODE_OFS);
    d.rdata = RD_ZERO;
    if (regWr && hit) begin
      d.fsEn  = regWdata[FS_EN_BIT];
      d.ioTim = regWdata[IO_TIM_BIT];
    end
    if (oneShotTaken) begin
      d.armed = 1'b0;
    end
    if (regWr && hit && !regWdata[ONE_SHOT_BIT]) begin
      d.armed = 1'b1;
    end
    if (regRd && hit) begin
      d.rdata[FS_EN_BIT]    = q.fsEn;
      d.rdata[ONE_SHOT_BIT] = 1'b1;
      d.rdata[IO_TIM_BIT]   = q.ioTim;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '{fsEn: FS_EN_RST, ioTim: IO_TIM_RST, armed: 1'b0, rdata: RD_ZERO};
    end else begin
      q <= d;
    end
  end

  assign regRdata     = q.rdata;
  assign fetchEnable  = q.fsEn;
  assign ioTiming     = q.ioTim;
  assign oneShotArmed = q.armed;

endmodule : bus_mode_regs
`default_nettype wire

// ===== src/cpu_bus_cycle_sequencer.sv
// Processor external bus machine cycle sequencer
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_sequencer
  import bus_seq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [REG_AW-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [7:0]        regRdata,
  input  wire logic              cycReq,
  input  wire cyc_req_s          cycCmd,
  output var  logic              cycReady,
  output var  logic              cycDone,
  output var  logic [7:0]        cycRdata,
  output var  logic              sysClkOut,
  output var  bus_pins_s         busPins,
  input  wire logic [7:0]        dataIn,
  input  wire logic              waitN
);

  typedef struct packed {
    bus_state_e  st;
    cyc_kind_e   kind;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        fetchOn;
    logic        waitLow;
    logic        waitForced;
    bus_pins_s   pins;
    logic [7:0]  rdData;
    logic        done;
  } seq_s;

  seq_s q;
  seq_s d;

  logic firstHalf;
  logic fetchEnable;
  logic ioTiming;
  logic oneShotArmed;
  logic oneShotTaken;
  logic accept;
  logic fetchNow;

  sys_clock_divider u_div (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .firstHalf (firstHalf),
    .sysClkOut (sysClkOut)
  );

  bus_mode_regs u_regs (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .regAddr      (regAddr),
    .regWdata     (regWdata),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdata     (regRdata),
    .oneShotTaken (oneShotTaken),
    .fetchEnable  (fetchEnable),
    .ioTiming     (ioTiming),
    .oneShotArmed (oneShotArmed)
  );

  // Pin levels for a given state and half of it
  function automatic bus_pins_s drivePins(
    input bus_state_e  st,
    input logic        secondHalf,
    input cyc_kind_e   kind,
    input logic [19:0] addr,
    input logic [7:0]  wdata,
    input logic        fetchOn,
    input logic        ioTim
  );
    bus_pins_s p;
    logic      active;
    logic      early;
    logic      late;
    p = PINS_IDLE;
    active = (st != ST_IDLE) && (kind != CYC_INTERNAL);
    // Window T1 second half to T3 first half
    early = ((st == ST_T1) && secondHalf) || (st == ST_T2) || (st == ST_TW)
          || ((st == ST_T3) && !secondHalf);
    // Window T2 start to T3 first half
    late = (st == ST_T2) || (st == ST_TW) || ((st == ST_T3) && !secondHalf);
    if (active) begin
      p.addr = addr;
      p.dataOut = wdata;
      if (!isIo(kind)) begin
        p.memReqN = ~early;
        p.rdN = ~(early && !isWrite(kind));
        p.wrN = ~(late && isWrite(kind));
      end else begin
        p.ioReqN = ioTim ? ~early : ~late;
        p.rdN = ~((ioTim ? early : late) && !isWrite(kind));
        p.wrN = ~(late && isWrite(kind));
      end
      // data from T1 end through T3
      p.dataOeN = ~(isWrite(kind) && (st != ST_T1));
      // fetch strobe through T3 first half
      p.fetchN = ~(fetchOn && ((st == ST_T1) || early));
    end
    return p;
  endfunction : drivePins

  assign fetchNow = (cycCmd.kind == CYC_MASKABLE_INTERRUPT_ZERO_ACK) || (cycCmd.kind == CYC_RETURN_FROM_INTERRUPT_FETCH)
                  || (isFetchLike(cycCmd.kind) && fetchEnable)
                  || (isOpFetch(cycCmd.kind) && oneShotArmed);

  // New cycle taken only at the end of a state, so T1 opens aligned
  assign accept = cycReq && !firstHalf
                && ((q.st == ST_IDLE) || (q.st == ST_T3)
                    || ((q.st == ST_T1) && (q.kind == CYC_INTERNAL)));

  assign cycReady = !firstHalf
                  && ((q.st == ST_IDLE) || (q.st == ST_T3)
                      || ((q.st == ST_T1) && (q.kind == CYC_INTERNAL)));

  // one shot used by next op fetch
  assign oneShotTaken = accept && isOpFetch(cycCmd.kind) && oneShotArmed;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!firstHalf) begin
      // End of a state: rising edge of the system clock
      case (q.st)
        ST_IDLE: begin
          d.st = ST_IDLE;
        end
        ST_T1: begin
          if (q.kind == CYC_INTERNAL) begin
            d.done = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.st = ST_T2;
          end
        end
        ST_T2, ST_TW: begin
          if (q.waitLow) begin
            d.st = ST_TW;
            d.waitForced = 1'b0;
          end else begin
            d.st = ST_T3;
            if (isFetchLike(q.kind)) begin
              d.rdData = dataIn;
            end
          end
        end
        ST_T3: begin
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
      if (accept) begin
        d.st = ST_T1;
        d.kind = cycCmd.kind;
        d.addr = isIo(cycCmd.kind) ? (cycCmd.addr & IO_ADDR_MASK) : cycCmd.addr;
        d.wdata = cycCmd.wdata;
        d.fetchOn = fetchNow;
        d.waitLow = 1'b0;
        // External io always gets one wait state
        d.waitForced = isIo(cycCmd.kind);
      end
    end else begin
      // Falling edge of the system clock
      if ((q.st == ST_T2) || (q.st == ST_TW)) begin
        d.waitLow = !waitN || q.waitForced;
      end
      if ((q.st == ST_T3) && !isFetchLike(q.kind) && !isWrite(q.kind)) begin
        d.rdData = dataIn;
      end
    end
    // pins follow state, steady across waits
    d.pins = drivePins(d.st, firstHalf, d.kind, d.addr, d.wdata, d.fetchOn, ioTiming);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '{st: ST_IDLE, kind: CYC_INTERNAL, addr: '0, wdata: '0, fetchOn: 1'b0,
             waitLow: 1'b0, waitForced: 1'b0, pins: PINS_IDLE, rdData: '0,
             done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign busPins  = q.pins;
  assign cycDone  = q.done;
  assign cycRdata = q.rdData;

endmodule : cpu_bus_cycle_sequencer
`default_nettype wire

// ===== test/bus_partner_model.sv
// Memory and I/O device model at the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module bus_partner_model
  import bus_seq_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire bus_pins_s  busPins,
  input  wire logic [1:0] waitCnt,
  output var  logic [7:0] dataIn,
  output var  logic       waitN,
  output var  logic [7:0] wrSeen
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] lastQ = 8'h00;
  logic       stb;
  assign stb = !busPins.memReqN || !busPins.ioReqN;
  // Slow device: two half states of wait request per wanted wait state
  assign waitN = !(stb && (cnt < {1'b0, waitCnt, 1'b0}));
  // Released bus flips every cycle so a late capture cannot pass by luck
  assign dataIn = busPins.rdN ? ~lastQ : (busPins.addr[7:0] ^ 8'h5A);
  always_ff @(posedge ref_clk) begin
    cnt <= stb ? cnt + 4'h1 : 4'h0;
    lastQ <= dataIn;
    if (!busPins.wrN) begin
      wrSeen <= busPins.dataOut;
    end
  end
endmodule : bus_partner_model
`default_nettype wire

// ===== test/bus_seq_assertions.sv
// Port checker of the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module bus_seq_assertions
  import bus_seq_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      sys_rst,
  input wire logic      cycDone,
  input wire logic      sysClkOut,
  input wire bus_pins_s busPins,
  input wire logic      waitN
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence stbJustLow;
    !busPins.memReqN && $past(busPins.memReqN, 2);
  endsequence
  sequence pinsFrozen;
    $stable(busPins)[*3];
  endsequence
  a_clk_halved: assert property (!$past(sys_rst) |-> sysClkOut != $past(sysClkOut))
    else $error("system clock not halved");
  a_wait_freeze: assert property (stbJustLow ##1 !waitN |=> ##1 pinsFrozen)
    else $error("pins moved in wait state");
  a_mem_req_len: assert property ($fell(busPins.memReqN) |-> !busPins.memReqN [*4])
    else $error("memory request too short");
  a_done_after_mem: assert property ($rose(busPins.memReqN) |=> cycDone)
    else $error("cycle not done after T3");
  a_done_pulse: assert property (cycDone |=> !cycDone)
    else $error("done longer than one cycle");
  a_io_addr_low: assert property (!busPins.ioReqN |-> busPins.addr[19:16] == 4'h0)
    else $error("upper address set in io cycle");
  a_req_exclusive: assert property (!(!busPins.ioReqN && !busPins.memReqN))
    else $error("both requests low");
  a_rd_with_req: assert property ($fell(busPins.rdN) |-> !(busPins.memReqN && busPins.ioReqN))
    else $error("read strobe without request");
  a_wr_with_data: assert property ($fell(busPins.wrN) |-> !busPins.dataOeN && busPins.rdN)
    else $error("write strobe without data");
  a_data_after_wr: assert property ($rose(busPins.wrN) |-> !busPins.dataOeN)
    else $error("data released with write strobe");
  a_no_fetch_wr: assert property (!busPins.wrN |-> busPins.fetchN)
    else $error("fetch strobe in write");
endmodule : bus_seq_assertions
bind cpu_bus_cycle_sequencer bus_seq_assertions chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .cycDone(cycDone), .sysClkOut(sysClkOut), .busPins(busPins), .waitN(waitN));
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top import bus_seq_pkg::*; ;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [3:0]  k;
    logic [19:0] a;
    logic        fe;
    logic [3:0]  so;
    logic [4:0]  ln;
    logic [1:0]  w;
  } row_s;
  logic       ref_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, cycReq = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, cycRdata, dataIn, wrSeen;
  logic       cycReady, cycDone, sysClkOut, waitN;
  logic [1:0] wCnt = 2'h0;
  cyc_req_s   cycCmd = '0;
  bus_pins_s  busPins;
  int         err_total = 0, samples_checked = 0;
  // Each wanted wait state costs two extra cycles; io rows carry the forced wait
  row_s rows [17] = '{
    '{8'hE0, 0, 20'h1_2345, 1, 2, 7, 0}, '{8'hE0, 4, 20'h2_3456, 0, 2, 7, 0},
    '{8'hE0, 1, 20'h3_4567, 1, 2, 7, 0}, '{8'hE0, 2, 20'h4_5678, 1, 2, 7, 0},
    '{8'hE0, 3, 20'h5_A0B1, 1, 2, 9, 0}, '{8'hE0, 5, 20'h6_789A, 0, 2, 7, 0},
    '{8'hE0, 6, 20'hA_BCDE, 0, 2, 9, 0}, '{8'hE0, 7, 20'hB_CDEF, 0, 2, 9, 0},
    '{8'hE0, 8, 20'h0_0000, 0, 0, 3, 0}, '{8'h40, 0, 20'h1_1111, 0, 2, 7, 0},
    '{8'h40, 1, 20'h2_2222, 1, 2, 7, 0}, '{8'h40, 2, 20'h3_3333, 0, 2, 7, 0},
    '{8'h40, 3, 20'h4_4444, 1, 3, 9, 0}, '{8'h40, 7, 20'h5_5555, 0, 3, 9, 0},
    '{8'h40, 0, 20'h6_6666, 0, 2, 11, 2}, '{8'h00, 0, 20'h7_7777, 1, 2, 7, 0},
    '{8'h40, 0, 20'h8_8888, 0, 2, 7, 0}};

  always #20 ref_clk = ~ref_clk;

  cpu_bus_cycle_sequencer uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cycReq(cycReq),
    .cycCmd(cycCmd), .cycReady(cycReady), .cycDone(cycDone), .cycRdata(cycRdata),
    .sysClkOut(sysClkOut), .busPins(busPins), .dataIn(dataIn), .waitN(waitN));
  bus_partner_model dev (.ref_clk(ref_clk), .busPins(busPins), .waitCnt(wCnt),
    .dataIn(dataIn), .waitN(waitN), .wrSeen(wrSeen));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk("mode register", e, regRdata);
  endtask : rd

  task automatic run(input row_s r);
    int          n;
    logic        fs;
    int          so;
    logic [19:0] sa;
    fs = 1'b0;
    so = 0;
    sa = '0;
    @(posedge ref_clk);
    wCnt <= r.w;
    cycCmd <= '{cyc_kind_e'(r.k), r.a, r.a[7:0] ^ 8'hC3};
    cycReq <= 1'b1;
    // Look only after the launch edge has settled, never in its own time step
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk);
      if (cycReady === 1'b1) break;
    end
    @(posedge ref_clk);
    cycReq <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(negedge ref_clk);
      fs = fs | !busPins.fetchN;
      if (so == 0 && !(busPins.memReqN && busPins.ioReqN)) begin
        so = n;
        sa = busPins.addr;
      end
      if (cycDone === 1'b1) break;
    end
    chk("cycle length", r.ln, n);
    chk("fetch strobe", r.fe, fs);
    chk("strobe start", r.so, so);
    chk("address", (r.k inside {3, 6, 7}) ? {4'h0, r.a[15:0]} : r.a, sa);
    if (!(r.k inside {5, 7, 8})) chk("read data", r.a[7:0] ^ 8'h5A, cycRdata);
    if (r.k inside {5, 7}) chk("write data", r.a[7:0] ^ 8'hC3, wrSeen);
  endtask : run

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'hE0);
    foreach (rows[i]) begin
      wr(8'h00, rows[i].cfg);
      run(rows[i]);
    end
    rd(8'h00, 8'h40);
    wr(8'h10, 8'hE0);
    rd(8'h10, 8'h00);
    rd(8'h00, 8'h40);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'hE0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
